/* File: rsc_core.sv */
// decode and execute of stack, call and return instructions
// Notes on behaviour
// RULE_01: pop discards top entry in one cycle
// RULE_02: entry below becomes new top after pop
// RULE_03: push writes pc plus two, one cycle
// RULE_04: old top moves one level down
// RULE_05: relative call decoded, eleven bit signed offset
// RULE_06: call pushes pc+2, jumps by twice offset
// RULE_07: call takes two cycles, second is idle
// RULE_08: software reset restores every register and flag
// RULE_09: interrupt return pops pc, sets enable, two cycles
// RULE_10: fast bit selects shadow restore or none
// RULE_11: shadow restore happens with the pc pop
// RULE_12: literal return loads literal into accumulator
// RULE_13: literal return reloads pc, two cycles
// RULE_14: returns leave pc high and upper latches
// RULE_15: one word per instruction, unknown opcodes idle
`timescale 1ns/10ps
`include "rsc_defines.svh"
module rsc_core
  import rsc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic high_priority_ctx_in,
  input wire logic [7:0] accumulator_shadow_in,
  input wire logic [7:0] flags_shadow_in,
  input wire logic [7:0] bank_select_shadow_in,
  input wire logic [7:0] pc_high_latch_in,
  input wire logic [7:0] pc_upper_latch_in,
  output logic [`RSC_PC_W-1:0] pc_out,
  output logic [`RSC_PC_W-1:0] stack_top_entry_out,
  output logic [`RSC_PTR_W-1:0] stack_depth_out,
  output logic [7:0] accumulator_out,
  output logic [7:0] flags_out,
  output logic [7:0] bank_select_reg_out,
  output logic [7:0] pc_high_latch_out,
  output logic [7:0] pc_upper_latch_out,
  output logic high_priority_global_irq_enable_out,
  output logic low_priority_global_irq_enable_out,
  output logic fetch_ready_out,
  output logic flush_out,
  output logic soft_reset_out
);
  rsc_state_t state;
  rsc_state_t next_state;
  logic [`RSC_PC_W-1:0] pc;
  logic [`RSC_PC_W-1:0] pc_plus2;
  logic [`RSC_PC_W-1:0] next_pc;
  logic [`RSC_PC_W-1:0] call_offset;
  logic [3:0] rst_cnt;
  logic [7:0] acc;
  logic [7:0] flags;
  logic [7:0] bank_select_reg;
  logic [7:0] latch_h;
  logic [7:0] latch_u;
  logic gie_h;
  logic gie_l;
  logic take;
  logic is_push;
  logic is_pop;
  logic is_relative_call_op;
  logic is_swrst;
  logic is_retie;
  logic is_literal_return_op;
  logic fast_ret;
  logic st_push;
  logic st_pop;
  logic st_clear;
  logic [`RSC_PC_W-1:0] stack_top_entry;
  logic [`RSC_OFFS_W-1:0] call_n;

  // decode of one 16-bit instruction word
  assign take = instr_valid_in && state == RSC_EXEC;
  assign is_push = take && instr_in == `RSC_OP_PUSH; // RULE_03
  assign is_pop = take && instr_in == `RSC_OP_POP; // RULE_01
  assign is_relative_call_op = take && instr_in[15:11] == `RSC_OP_RELATIVE_CALL_OP_HI; // RULE_05
  assign is_swrst = take && instr_in == `RSC_OP_RESET; // RULE_08
  assign is_retie = take && instr_in[15:1] == `RSC_OP_RETIE_HI; // RULE_09
  assign is_literal_return_op = take && instr_in[15:8] == `RSC_OP_LITERAL_RETURN_OP_HI; // RULE_12
  assign fast_ret = instr_in[0]; // RULE_10
  assign pc_plus2 = pc + `RSC_PC_STEP; // RULE_15
  // sign extend and double the word offset
  assign call_offset = {{(`RSC_PC_W-`RSC_OFFS_W-1){instr_in[10]}}, instr_in[10:0], 1'b0}; // RULE_06
  assign call_n = instr_in[`RSC_OFFS_W-1:0];

  assign st_push = is_push || is_relative_call_op; // RULE_04
  assign st_pop = is_pop || is_retie || is_literal_return_op; // RULE_02
  assign st_clear = state == RSC_SWRST;

  rsc_stack u_stack (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(st_clear),
    .push_in(st_push),
    .pop_in(st_pop),
    .push_data_in(pc_plus2),
    .stack_top_entry_out(stack_top_entry),
    .depth_out(stack_depth_out)
  );

  always_comb begin
    next_pc = pc;
    next_state = state;
    unique case (state)
      RSC_EXEC: begin
        if (is_relative_call_op) begin
          next_pc = pc_plus2 + call_offset; // RULE_06
          next_state = RSC_FLUSH; // RULE_07
        end else if (is_retie || is_literal_return_op) begin
          next_pc = stack_top_entry; // RULE_09 RULE_13
          next_state = RSC_FLUSH;
        end else if (is_swrst) begin
          next_pc = `RSC_PC_RESET;
          next_state = RSC_SWRST;
        end else if (take) begin
          next_pc = pc_plus2; // RULE_15
        end
      end
      RSC_FLUSH: begin
        next_state = RSC_EXEC; // RULE_07
      end
      RSC_SWRST: begin
        next_pc = `RSC_PC_RESET;
        if (rst_cnt == '0) begin
          next_state = RSC_EXEC;
        end
      end
      default: begin
        next_state = RSC_EXEC;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= RSC_EXEC;
      pc <= `RSC_PC_RESET;
    end else begin
      state <= next_state;
      pc <= next_pc;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_cnt <= '0;
    end else if (is_swrst) begin
      rst_cnt <= `RSC_RESET_STRETCH; // RULE_08
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - 4'h1;
    end
  end

  // working registers and shadow restore
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc <= '0;
      flags <= '0;
      bank_select_reg <= '0;
    end else if (st_clear) begin
      acc <= '0; // RULE_08
      flags <= '0;
      bank_select_reg <= '0;
    end else if (is_literal_return_op) begin
      acc <= instr_in[7:0]; // RULE_12
    end else if (is_retie && fast_ret) begin
      acc <= accumulator_shadow_in; // RULE_11
      flags <= flags_shadow_in;
      bank_select_reg <= bank_select_shadow_in;
    end
  end

  // pc latches follow external writes and clear on soft reset, returns never touch them
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_h <= '0;
      latch_u <= '0;
    end else if (st_clear) begin
      latch_h <= '0;
      latch_u <= '0;
    end else if (!(is_retie || is_literal_return_op)) begin
      latch_h <= pc_high_latch_in; // RULE_14
      latch_u <= pc_upper_latch_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gie_h <= 1'b0;
      gie_l <= 1'b0;
    end else if (st_clear) begin
      gie_h <= 1'b0;
      gie_l <= 1'b0;
    end else if (is_retie) begin
      if (high_priority_ctx_in) begin
        gie_h <= 1'b1; // RULE_09
      end else begin
        gie_l <= 1'b1;
      end
    end
  end

  assign pc_out = pc;
  assign stack_top_entry_out = stack_top_entry;
  assign accumulator_out = acc;
  assign flags_out = flags;
  assign bank_select_reg_out = bank_select_reg;
  assign pc_high_latch_out = latch_h;
  assign pc_upper_latch_out = latch_u;
  assign high_priority_global_irq_enable_out = gie_h;
  assign low_priority_global_irq_enable_out = gie_l;
  assign fetch_ready_out = state == RSC_EXEC;
  assign flush_out = state == RSC_FLUSH;
  assign soft_reset_out = state == RSC_SWRST;

  chk_push_top: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    is_push && stack_depth_out != 5'h1f |=> stack_top_entry == $past(pc_plus2)) else $error("push top wrong"); // RULE_03
  sequence s_push_gap_pop;
    is_push ##1 (!st_push && !st_pop) ##1 is_pop;
  endsequence
  chk_pop_below: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_push_gap_pop |=> stack_top_entry == $past(stack_top_entry, 3)) else $error("pop top wrong"); // RULE_02
  chk_call_target: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    is_relative_call_op |=> pc == $past(pc) + `RSC_PC_STEP + (`RSC_PC_W'($signed($past(call_n))) << 1))
    else $error("call target wrong"); // RULE_06
  sequence s_call_idle;
    flush_out ##1 fetch_ready_out;
  endsequence
  chk_call_cycles: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    is_relative_call_op |=> s_call_idle) else $error("call not two cycles"); // RULE_07
  chk_ret_pc: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (is_retie || is_literal_return_op) |=> pc == $past(stack_top_entry) && flush_out) else $error("return pc wrong"); // RULE_13
  chk_retie_gie: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    is_retie |=> ($past(high_priority_ctx_in) ? gie_h : gie_l)) else $error("no enable set"); // RULE_09
  chk_literal_return_op_acc: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    is_literal_return_op |=> acc == $past(instr_in[7:0])) else $error("literal not loaded"); // RULE_12
  chk_shadow_keep: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    is_retie && !fast_ret |=> $stable(acc) && $stable(flags) && $stable(bank_select_reg))
    else $error("shadow restore unexpected"); // RULE_10
  chk_latch_keep: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (is_retie || is_literal_return_op) |=> $stable(latch_h) && $stable(latch_u)) else $error("latch changed"); // RULE_14
  chk_swrst_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    is_swrst |=> ##1 stack_depth_out == '0 && acc == '0 && pc == '0) else $error("soft reset incomplete"); // RULE_08
endmodule

/* File: rsc_defines.svh */
// constants for the return stack and call/return decoder
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH
`define RSC_PC_W 21
`define RSC_STACK_DEPTH 31
`define RSC_PTR_W 5
`define RSC_PC_STEP 21'h000002
`define RSC_PC_RESET 21'h000000
`define RSC_OP_NOP 16'h0000
`define RSC_OP_PUSH 16'h0005
`define RSC_OP_POP 16'h0006
`define RSC_OP_RESET 16'h00ff
`define RSC_OP_RETIE_HI 15'h0008
`define RSC_OP_LITERAL_RETURN_OP_HI 8'h0c
`define RSC_OP_RELATIVE_CALL_OP_HI 5'h1b
`define RSC_OFFS_W 11
`define RSC_RESET_STRETCH 4'h4
`endif

/* File: rsc_pkg.sv */
// types for the return stack and call/return decoder
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_EXEC = 2'b00,
    RSC_FLUSH = 2'b01,
    RSC_SWRST = 2'b10
  } rsc_state_t;
endpackage

/* File: rsc_stack.sv */
// return stack storage with push, pop and top
`timescale 1ns/10ps
`include "rsc_defines.svh"
module rsc_stack
  import rsc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [`RSC_PC_W-1:0] push_data_in,
  output logic [`RSC_PC_W-1:0] stack_top_entry_out,
  output logic [`RSC_PTR_W-1:0] depth_out
);
  logic [`RSC_PC_W-1:0] entry [`RSC_STACK_DEPTH];
  logic [`RSC_PTR_W-1:0] depth;
  genvar gi;
  generate
    for (gi = 0; gi < `RSC_STACK_DEPTH; gi++) begin : g_entry
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          entry[gi] <= `RSC_PC_RESET;
        end else if (clear_in) begin
          entry[gi] <= `RSC_PC_RESET;
        end else if (push_in && depth == `RSC_PTR_W'(gi)) begin
          entry[gi] <= push_data_in;
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      depth <= '0;
    end else if (clear_in) begin
      depth <= '0;
    end else if (push_in && depth != `RSC_PTR_W'(`RSC_STACK_DEPTH)) begin
      depth <= depth + `RSC_PTR_W'(1);
    end else if (pop_in && depth != '0) begin
      depth <= depth - `RSC_PTR_W'(1);
    end
  end
  assign depth_out = depth;
  assign stack_top_entry_out = (depth == '0) ? `RSC_PC_RESET : entry[depth - `RSC_PTR_W'(1)];
endmodule

/* File: rsc_fetch_model.sv */
// fetch stage model offering one instruction word at a time
`timescale 1ns/10ps
module rsc_fetch_model (
  input wire logic ref_clk_in,
  input wire logic fetch_ready_in,
  output logic instr_valid_out,
  output logic [15:0] instr_out
);
  initial begin
    instr_valid_out = 1'b0;
    instr_out = 16'h0000;
  end
  // called just after a rising edge; holds the word until taken
  task automatic issue(input logic [15:0] w);
    instr_valid_out <= 1'b1;
    instr_out <= w;
    @(posedge ref_clk_in);
    while (fetch_ready_in !== 1'b1) @(posedge ref_clk_in);
    instr_valid_out <= 1'b0;
    instr_out <= ~w;
  endtask
endmodule

/* File: return_stack_call_return_ops_bench.sv */
// self-checking bench for the call/return decoder
`timescale 1ns/10ps
module return_stack_call_return_ops_bench;
  logic clk = 1'b0, rst_n = 1'b0, hp = 1'b0, iv;
  logic [15:0] iw;
  logic [7:0] ws = 8'h00, fs = 8'h00, bs = 8'h00, hl = 8'h3c, ul = 8'h05;
  logic [7:0] acc, flg, bank_select_reg, hlo, ulo;
  logic [20:0] pc, top;
  logic [4:0] dep;
  logic hen, len, rdy, fl, sr;
  int error_cnt = 0, total_checks = 0;
  always #2 clk = ~clk;
  rsc_fetch_model fm (.ref_clk_in(clk), .fetch_ready_in(rdy), .instr_valid_out(iv), .instr_out(iw));
  rsc_core uut (.ref_clk_in(clk), .rst_n_in(rst_n), .instr_valid_in(iv), .instr_in(iw),
    .high_priority_ctx_in(hp), .accumulator_shadow_in(ws), .flags_shadow_in(fs),
    .bank_select_shadow_in(bs), .pc_high_latch_in(hl), .pc_upper_latch_in(ul), .pc_out(pc),
    .stack_top_entry_out(top), .stack_depth_out(dep), .accumulator_out(acc), .flags_out(flg),
    .bank_select_reg_out(bank_select_reg), .pc_high_latch_out(hlo), .pc_upper_latch_out(ulo),
    .high_priority_global_irq_enable_out(hen), .low_priority_global_irq_enable_out(len),
    .fetch_ready_out(rdy), .flush_out(fl), .soft_reset_out(sr));
  task automatic chk_val(input string nm, input logic [20:0] e, input logic [20:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  // one word; two-cycle ops must show the idle flush cycle
  task automatic go(input logic [15:0] w, input logic two);
    fm.issue(w);
    #1;
    chk_bit("flush", two, fl);
    chk_bit("ready", ~two, rdy);
  endtask
  task automatic run(input logic [15:0] w, input logic two);
    @(posedge clk);
    go(w, two);
  endtask
  task automatic stk(input logic [20:0] p, input logic [20:0] t, input logic [4:0] d);
    chk_val("pc", p, pc);
    chk_val("top", t, top);
    chk_val("depth", {16'h0000, d}, {16'h0000, dep});
  endtask
  task automatic t_push_pop();
    run(16'h0005, 1'b0);
    stk(21'h000002, 21'h000002, 5'h01);
    chk_val("hlatch", 21'h00003c, {13'h0000, hlo});
    run(16'h0005, 1'b0);
    stk(21'h000004, 21'h000004, 5'h02);
    run(16'h0006, 1'b0);
    stk(21'h000006, 21'h000002, 5'h01);
  endtask
  task automatic t_call();
    run(16'hdfff, 1'b1);
    stk(21'h000006, 21'h000008, 5'h02);
    run(16'hdbff, 1'b1);
    stk(21'h000806, 21'h000008, 5'h03);
    run(16'hf123, 1'b0);
    stk(21'h000808, 21'h000008, 5'h03);
  endtask
  task automatic t_returns();
    @(posedge clk);
    hl <= 8'h77;
    ul <= 8'h66;
    go(16'h0c5a, 1'b1);
    stk(21'h000008, 21'h000008, 5'h02);
    chk_val("acc", 21'h00005a, {13'h0000, acc});
    chk_val("hlatch", 21'h00003c, {13'h0000, hlo});
    chk_val("ulatch", 21'h000005, {13'h0000, ulo});
    @(posedge clk);
    ws <= 8'ha1;
    fs <= 8'hb2;
    bs <= 8'hc3;
    hp <= 1'b1;
    go(16'h0011, 1'b1);
    stk(21'h000008, 21'h000002, 5'h01);
    chk_val("acc", 21'h0000a1, {13'h0000, acc});
    chk_val("flags", 21'h0000b2, {13'h0000, flg});
    chk_val("bsr", 21'h0000c3, {13'h0000, bank_select_reg});
    chk_bit("hien", 1'b1, hen);
    @(posedge clk);
    ws <= 8'h12;
    fs <= 8'h34;
    bs <= 8'h56;
    hp <= 1'b0;
    go(16'h0010, 1'b1);
    stk(21'h000002, 21'h000000, 5'h00);
    chk_val("acc", 21'h0000a1, {13'h0000, acc});
    chk_val("bsr", 21'h0000c3, {13'h0000, bank_select_reg});
    chk_bit("loen", 1'b1, len);
  endtask
  task automatic t_soft_reset();
    run(16'h0005, 1'b0);
    @(posedge clk);
    fm.issue(16'h00ff);
    for (int i = 0; i < 5; i++) begin
      #1;
      chk_bit("swrst", 1'b1, sr);
      @(posedge clk);
    end
    #1;
    chk_bit("ready", 1'b1, rdy);
    stk(21'h000000, 21'h000000, 5'h00);
    chk_val("acc", 21'h000000, {13'h0000, acc});
    chk_val("flags", 21'h000000, {13'h0000, flg});
    chk_bit("loen", 1'b0, len);
    chk_bit("hien", 1'b0, hen);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_push_pop();
    t_call();
    t_returns();
    t_soft_reset();
    wrap_up();
  end
endmodule
